//--- remote_tx_far_side.sv
// key matrix, sense switch and board model on the far side of the ports
`timescale 1ns/10ps
module remote_tx_far_side (
  input wire logic clk,
  input wire logic in_reset,
  input wire logic [7:0] scan_press,
  input wire logic [3:0] ret_press,
  input wire logic sense_press,
  input wire logic [7:0] scan_out,
  input wire logic [7:0] scan_oe,
  input wire logic [7:0] scan_pd,
  input wire logic [3:0] ret_pd,
  input wire logic sa_en,
  input wire logic sa_pd,
  input wire logic sb_out,
  input wire logic sb_oe,
  input wire logic sb_pd,
  output logic [7:0] scan_in,
  output logic [3:0] ret_in,
  output logic sa_in,
  output logic sb_in
);
  logic flt = 1'b0;
  // a floating line shows a level that changes every cycle
  always_ff @(posedge clk) begin
    flt <= ~flt;
  end
  // pressed keys pull high; otherwise pull-down or floating
  always_comb begin
    scan_in = (scan_oe & scan_out) | (~scan_oe & (scan_press | (~scan_pd & {8{flt}})));
    ret_in = in_reset ? 4'h0 : (ret_press | (~ret_pd & {4{flt}}));
    sa_in = sa_en ? (sense_press | (~sa_pd & flt)) : flt;
    sb_in = sb_oe ? sb_out : (sense_press | (~sb_pd & flt));
  end
endmodule

//--- remote_tx_pin_ports.sv
// pin-level port logic with apb register access
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module remote_tx_pin_ports
  import remote_tx_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [7:0] KEYSCAN_IN,
  output logic [7:0] KEYSCAN_OUT,
  output logic [7:0] KEYSCAN_OE,
  output logic [7:0] KEYSCAN_PD,
  input wire logic [3:0] KEYRET_IN,
  output logic [3:0] KEYRET_PD,
  input wire logic SENSE_A_IN,
  output logic SENSE_A_EN,
  output logic SENSE_A_PD,
  input wire logic SENSE_B_OR_INDICATOR_IN,
  output logic SENSE_B_OR_INDICATOR_OUT,
  output logic SENSE_B_OR_INDICATOR_OE,
  output logic SENSE_B_PD,
  output logic IR_CARRIER_OUT,
  input wire logic POWER_ON_CLEAR,
  output logic RESET_PIN_OUT,
  output logic RESET_PIN_OE,
  output logic CPU_RESET_N
);

  logic [SY_W-1:0] sync_meta;
  logic [SY_W-1:0] sync_pin;
  logic [7:0] scan_latch;
  logic [5:0] ctrl;
  logic [2:0] car_sel;
  logic tx_en;
  logic [7:0] car_cnt;
  logic [7:0] car_div;
  logic car_phase;
  logic next_ir;
  logic setup;
  logic wr;
  logic car_wr;
  logic mapped;
  logic [31:0] next_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  //////////////////////////////////////////////////////////////////////////////

  // two flops for every pin input
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      sync_meta <= '0;
      sync_pin <= '0;
    end else begin
      sync_meta <= {POWER_ON_CLEAR, SENSE_B_OR_INDICATOR_IN, SENSE_A_IN,
                    KEYRET_IN, KEYSCAN_IN};
      sync_pin <= sync_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb decode
  //////////////////////////////////////////////////////////////////////////////

  // setup cycle starts a transfer, write lands in access cycle
  assign setup = PSEL && !PENABLE;
  assign wr = PSEL && PENABLE && PWRITE && PREADY;
  assign car_wr = wr && (PADDR == OFS_CARRIER);

  // read mux and address check
  always_comb begin
    next_rdata = '0;
    mapped = 1'b1;
    if (PADDR == OFS_SCAN_DATA) begin
      next_rdata[7:0] = ctrl[CTL_SCAN_DIR] ? scan_latch
                                           : sync_pin[7:0];
    end else if (PADDR == OFS_PIN_STATE) begin
      next_rdata[3:0] = sync_pin[SY_RET+3:SY_RET];
      // sense a reads one while switched off
      next_rdata[4] = ctrl[CTL_SENSE_A_IN] ? sync_pin[SY_SA] : 1'b1;
      next_rdata[5] = sync_pin[SY_SB];
    end else if (PADDR == OFS_CTRL_B) begin
      next_rdata[5:0] = ctrl;
    end else if (PADDR == OFS_CARRIER) begin
      next_rdata[3:0] = {tx_en, car_sel};
    end else begin
      mapped = 1'b0;
    end
  end

  // one wait-free access phase per transfer
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup && !mapped;
      if (setup && !PWRITE) begin
        PRDATA <= next_rdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers
  //////////////////////////////////////////////////////////////////////////////

  // key-scan output latch
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      scan_latch <= SCAN_RESET;
    end else if (wr && PADDR == OFS_SCAN_DATA) begin
      scan_latch <= PWDATA[7:0];
    end
  end

  // port control b, reserved bits stay zero
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ctrl <= CTL_RESET;
    end else if (wr && PADDR == OFS_CTRL_B) begin
      ctrl <= PWDATA[5:0] & CTL_MASK;
    end
  end

  // carrier select and transmit enable
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      car_sel <= SEL_DIV8;
      tx_en <= 1'b0;
    end else if (car_wr) begin
      car_sel <= PWDATA[2:0];
      tx_en <= PWDATA[CAR_TX_EN];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // carrier generator
  //////////////////////////////////////////////////////////////////////////////

  // divisor per select code
  always_comb begin
    case (car_sel)
      SEL_DIV16: car_div = DIV16;
      SEL_DIV64: car_div = DIV64;
      SEL_DIV96: car_div = DIV96;
      SEL_DIV128: car_div = DIV128;
      SEL_DIV192: car_div = DIV192;
      default: car_div = DIV8;
    endcase
  end

  // cycle counter, restarted by any carrier write
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      car_cnt <= '0;
    end else if (car_wr || !tx_en || car_cnt == car_div - 8'h01) begin
      car_cnt <= '0;
    end else begin
      car_cnt <= car_cnt + 8'h01;
    end
  end

  // high for the first half of each period
  assign car_phase = car_cnt < {1'b0, car_div[7:1]};
  assign next_ir = tx_en && ((car_sel[1:0] == SEL_HIGH[1:0])
                             || car_phase);

  // infrared output, active high
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      IR_CARRIER_OUT <= 1'b0;
    end else begin
      IR_CARRIER_OUT <= next_ir;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin drivers
  //////////////////////////////////////////////////////////////////////////////

  // key-scan port, all eight bits turn together
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      KEYSCAN_OUT <= SCAN_RESET;
      KEYSCAN_OE <= 8'hFF;
      KEYSCAN_PD <= 8'h00;
    end else begin
      KEYSCAN_OUT <= scan_latch;
      KEYSCAN_OE <= {8{ctrl[CTL_SCAN_DIR]}};
      KEYSCAN_PD <= {8{!ctrl[CTL_SCAN_DIR]}};
    end
  end

  // key-return pull-downs share one bit
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      KEYRET_PD <= 4'hF;
    end else begin
      KEYRET_PD <= {4{ctrl[CTL_RET_PD]}};
    end
  end

  // sense a: off mode floats with no pull-down
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      SENSE_A_EN <= 1'b0;
      SENSE_A_PD <= 1'b0;
    end else begin
      SENSE_A_EN <= ctrl[CTL_SENSE_A_IN];
      SENSE_A_PD <= ctrl[CTL_SENSE_A_IN] && ctrl[CTL_SENSE_PD];
    end
  end

  // shared sense pin: input or active-low transmit lamp
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      SENSE_B_OR_INDICATOR_OUT <= 1'b1;
      SENSE_B_OR_INDICATOR_OE <= 1'b1;
      SENSE_B_PD <= 1'b0;
    end else begin
      SENSE_B_OR_INDICATOR_OUT <= !tx_en;
      SENSE_B_OR_INDICATOR_OE <= ctrl[CTL_IND_OUT];
      SENSE_B_PD <= !ctrl[CTL_IND_OUT] && ctrl[CTL_SENSE_PD];
    end
  end

  // power-on clear pulls the reset pin low
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      RESET_PIN_OUT <= 1'b0;
      RESET_PIN_OE <= 1'b0;
      CPU_RESET_N <= 1'b0;
    end else begin
      RESET_PIN_OUT <= 1'b0;
      RESET_PIN_OE <= sync_pin[SY_POC];
      CPU_RESET_N <= !sync_pin[SY_POC];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  //////////////////////////////////////////////////////////////////////////////

  property p_scan_reset;
    @(posedge REF_CLK)
    $rose(RST_N) |-> KEYSCAN_OE == 8'hFF && KEYSCAN_OUT == 8'hFF;
  endproperty
  a_scan_reset: assert property (p_scan_reset)
    else $error("key-scan not high output after reset");

  property p_scan_dir;
    @(posedge REF_CLK) disable iff (!RST_N)
    ctrl[CTL_SCAN_DIR] |=> KEYSCAN_OE == 8'hFF && KEYSCAN_PD == 8'h00
      && KEYSCAN_OUT == $past(scan_latch);
  endproperty
  a_scan_dir: assert property (p_scan_dir)
    else $error("key-scan output mode wrong");

  property p_scan_in;
    @(posedge REF_CLK) disable iff (!RST_N)
    !ctrl[CTL_SCAN_DIR] |=> KEYSCAN_OE == 8'h00 && KEYSCAN_PD == 8'hFF;
  endproperty
  a_scan_in: assert property (p_scan_in)
    else $error("key-scan input mode wrong");

  property p_sense_off;
    @(posedge REF_CLK) disable iff (!RST_N)
    !ctrl[CTL_SENSE_A_IN] |=> !SENSE_A_EN && !SENSE_A_PD;
  endproperty
  a_sense_off: assert property (p_sense_off)
    else $error("sense a not off");

  property p_sense_pd;
    @(posedge REF_CLK) disable iff (!RST_N)
    ctrl[CTL_SENSE_A_IN] && !ctrl[CTL_IND_OUT] |=>
      SENSE_A_PD == SENSE_B_PD;
  endproperty
  a_sense_pd: assert property (p_sense_pd)
    else $error("sense pull-downs differ");
  property p_lamp;
    @(posedge REF_CLK) disable iff (!RST_N)
    ctrl[CTL_IND_OUT] ##1 ctrl[CTL_IND_OUT] |->
      SENSE_B_OR_INDICATOR_OE && (SENSE_B_OR_INDICATOR_OUT == !$past(tx_en));
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("lamp not in step with transmit");
  property p_ir_idle;
    @(posedge REF_CLK) disable iff (!RST_N)
    !tx_en |=> !IR_CARRIER_OUT && SENSE_B_OR_INDICATOR_OUT;
  endproperty
  a_ir_idle: assert property (p_ir_idle)
    else $error("output active while idle");
  property p_ir_high;
    @(posedge REF_CLK) disable iff (!RST_N)
    tx_en && car_sel == SEL_HIGH |=> IR_CARRIER_OUT;
  endproperty
  a_ir_high: assert property (p_ir_high)
    else $error("no-carrier mode not high");

  property p_div8;
    @(posedge REF_CLK) disable iff (!RST_N)
    $rose(IR_CARRIER_OUT) ##0 (tx_en && car_sel == SEL_DIV8 && !car_wr)[*8]
      |=> $rose(IR_CARRIER_OUT);
  endproperty
  a_div8: assert property (p_div8)
    else $error("divide-by-8 period wrong");

  property p_poc;
    @(posedge REF_CLK) disable iff (!RST_N)
    sync_pin[SY_POC] |=> RESET_PIN_OE && !RESET_PIN_OUT && !CPU_RESET_N;
  endproperty
  a_poc: assert property (p_poc)
    else $error("power-on clear not driving reset");

  property p_ret_pd;
    @(posedge REF_CLK) disable iff (!RST_N)
    ##1 1'b1 |-> KEYRET_PD == {4{$past(ctrl[CTL_RET_PD])}};
  endproperty
  a_ret_pd: assert property (p_ret_pd)
    else $error("key-return pull-downs wrong");

  property p_scan_read;
    @(posedge REF_CLK) disable iff (!RST_N)
    setup && !PWRITE && PADDR == OFS_SCAN_DATA && ctrl[CTL_SCAN_DIR]
      |=> PRDATA[7:0] == $past(scan_latch);
  endproperty
  a_scan_read: assert property (p_scan_read)
    else $error("key-scan read not latch");

endmodule

//--- remote_tx_pin_ports_test.sv
// self-checking bench for the remote transmitter pin ports
`timescale 1ns/10ps
module remote_tx_pin_ports_test;
  import remote_tx_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, power_on_clear = 1'b0, sense_press = 1'b0;
  logic [7:0] scan_press = 8'h00, scan_in, scan_out, scan_oe, scan_pd;
  logic [3:0] ret_press = 4'h0, ret_in, ret_pd;
  logic sa_in, sa_en, sa_pd, sb_in, sb_out, sb_oe, sb_pd, ir;
  logic rp_out, rp_oe, cpu_n;
  logic [23:0] scan_w;
  logic [11:0] misc;
  logic err_dummy;
  logic [31:0] rd_dummy;
  logic [2:0] sel_tab [6] = '{SEL_DIV8, SEL_DIV16, SEL_DIV64, SEL_DIV96,
    SEL_DIV128, SEL_DIV192};
  int div_tab [6] = '{8, 16, 64, 96, 128, 192};
  int err_total = 0;
  int checks_done = 0;
  assign scan_w = {scan_out, scan_oe, scan_pd};
  assign misc = {ret_pd, sa_en, sa_pd, sb_oe, sb_out, sb_pd, ir, rp_oe, cpu_n};
  // clock of 10 ns
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  remote_tx_pin_ports remote_tx_pin_ports_inst (.REF_CLK(ref_clk),
    .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .KEYSCAN_IN(scan_in), .KEYSCAN_OUT(scan_out),
    .KEYSCAN_OE(scan_oe), .KEYSCAN_PD(scan_pd), .KEYRET_IN(ret_in),
    .KEYRET_PD(ret_pd), .SENSE_A_IN(sa_in), .SENSE_A_EN(sa_en),
    .SENSE_A_PD(sa_pd), .SENSE_B_OR_INDICATOR_IN(sb_in),
    .SENSE_B_OR_INDICATOR_OUT(sb_out), .SENSE_B_OR_INDICATOR_OE(sb_oe),
    .SENSE_B_PD(sb_pd), .IR_CARRIER_OUT(ir), .POWER_ON_CLEAR(power_on_clear),
    .RESET_PIN_OUT(rp_out), .RESET_PIN_OE(rp_oe), .CPU_RESET_N(cpu_n));
  remote_tx_far_side remote_tx_far_side_inst (.clk(ref_clk),
    .in_reset(~rst_n), .scan_press(scan_press), .ret_press(ret_press),
    .sense_press(sense_press), .scan_out(scan_out), .scan_oe(scan_oe),
    .scan_pd(scan_pd), .ret_pd(ret_pd), .sa_en(sa_en), .sa_pd(sa_pd),
    .sb_out(sb_out), .sb_oe(sb_oe), .sb_pd(sb_pd), .scan_in(scan_in),
    .ret_in(ret_in), .sa_in(sa_in), .sb_in(sb_in));
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one apb transfer, waiting on pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      give_verdict();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk({35'h0, e}, 36'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk({3'h0, e, q}, {4'h0, x});
  endtask
  task automatic meas(input int div);
    int h, l, n;
    h = 0;
    l = 0;
    n = 0;
    // skip the first period, it may merge with the old carrier
    while (ir !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    while (ir === 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    while (ir !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    while (ir === 1'b1 && h < 400) begin
      tick(1);
      h++;
    end
    while (ir !== 1'b1 && l < 400) begin
      tick(1);
      l++;
    end
    if (n >= 400 || h >= 400 || l >= 400) begin
      err_total++;
      give_verdict();
    end
    chk(36'(h + l), 36'(div));
    chk(36'(h), 36'(div / 2));
    chk({35'h0, sb_out}, 36'h0);
  endtask
  task automatic check_reset();
    chk({12'h0, scan_w}, 36'hFFFF00);
    chk({24'h0, misc}, 36'hF31);
    rd(OFS_CTRL_B, 32'h26);
    rd(OFS_SCAN_DATA, 32'hFF);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    tick(2);
    rst_n <= 1'b1;
    tick(3);
    check_reset();
    ret_press <= 4'hA;
    tick(4);
    rd(OFS_PIN_STATE, 32'h3A);
    wr(OFS_PIN_STATE, 32'h0);
    rd(OFS_PIN_STATE, 32'h3A);
    apb(1'b1, 8'h10, 32'hFFFFFFFF, rd_dummy, err_dummy);
    chk({35'h0, err_dummy}, 36'h1);
    wr(OFS_CTRL_B, 32'h3F);
    rd(OFS_CTRL_B, 32'h37);
    wr(OFS_CTRL_B, 32'h31);
    tick(2);
    chk({12'h0, scan_w}, 36'hFF00FF);
    chk({24'h0, misc}, 36'hFD9);
    scan_press <= 8'h81;
    sense_press <= 1'b1;
    tick(4);
    rd(OFS_SCAN_DATA, 32'h81);
    rd(OFS_PIN_STATE, 32'h3A);
    wr(OFS_SCAN_DATA, 32'h5A);
    wr(OFS_CTRL_B, 32'h01);
    tick(2);
    chk({24'h0, misc}, 36'h091);
    wr(OFS_CTRL_B, 32'h00);
    tick(2);
    chk({24'h0, misc}, 36'h011);
    wr(OFS_CTRL_B, 32'h26);
    tick(2);
    chk({12'h0, scan_w}, 36'h5AFF00);
    rd(OFS_SCAN_DATA, 32'h5A);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CARRIER, {28'h0, 1'b1, sel_tab[i]});
      meas(div_tab[i]);
    end
    wr(OFS_CARRIER, {28'h0, 1'b1, SEL_HIGH});
    tick(3);
    repeat (8) begin
      tick(1);
      chk({34'h0, ir, sb_out}, 36'h2);
    end
    wr(OFS_CARRIER, 32'hF);
    tick(3);
    chk({35'h0, ir}, 36'h1);
    wr(OFS_CARRIER, {28'h0, 1'b0, SEL_HIGH});
    tick(2);
    chk({24'h0, misc}, 36'hF31);
    chk({35'h0, rp_out}, 36'h0);
    power_on_clear <= 1'b1;
    tick(5);
    chk({24'h0, misc}, 36'hF32);
    chk({35'h0, rp_out}, 36'h0);
    power_on_clear <= 1'b0;
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(3);
    check_reset();
    give_verdict();
  end
endmodule

//--- remote_tx_pkg.sv
// constants and encodings for the remote transmitter pin ports
//
// Behaviour
// - the key-scan port turns all eight bits around together and leaves reset driving high.
// - key-scan bits get pull-downs as inputs and drive the latch as scan lines as outputs.
// - with its input mode cancelled the first sense pin floats off, and that is its reset state.
// - one control bit turns the pull-downs of both sense inputs on or off together.
// - as an output the shared sense pin is an active-low transmit lamp, low with the carrier, high out of reset.
// - the infrared output is active high and stays low until transmission is ordered.
// - the carrier divides the oscillator by 8, 16, 64, 96, 128 or 192, or holds a steady high.
// - a low reset pin resets the core, and a power-on clear pulls the reset pin low itself.
// - one control bit turns the pull-downs of all four key-return inputs on or off together.
// - bit one of the second port control register selects the key-scan direction.
// - a key-scan read gives the pins as input and the output latch as output.
////////////////////////////////////////////////////////////////////////////////
package remote_tx_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_SCAN_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL_B = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CARRIER = 8'h0C;
  // port_control_reg_b fields
  localparam int CTL_SENSE_A_IN = 0;
  localparam int CTL_SCAN_DIR = 1;
  localparam int CTL_IND_OUT = 2;
  localparam int CTL_SENSE_PD = 4;
  localparam int CTL_RET_PD = 5;
  localparam logic [5:0] CTL_MASK = 6'h37;
  localparam logic [5:0] CTL_RESET = 6'h26;
  localparam logic [7:0] SCAN_RESET = 8'hFF;
  // carrier register fields
  localparam int CAR_TX_EN = 3;
  localparam logic [2:0] SEL_DIV8 = 3'h0;
  localparam logic [2:0] SEL_DIV64 = 3'h1;
  localparam logic [2:0] SEL_DIV96 = 3'h2;
  localparam logic [2:0] SEL_HIGH = 3'h3;
  localparam logic [2:0] SEL_DIV16 = 3'h4;
  localparam logic [2:0] SEL_DIV128 = 3'h5;
  localparam logic [2:0] SEL_DIV192 = 3'h6;
  localparam logic [7:0] DIV8 = 8'h08;
  localparam logic [7:0] DIV16 = 8'h10;
  localparam logic [7:0] DIV64 = 8'h40;
  localparam logic [7:0] DIV96 = 8'h60;
  localparam logic [7:0] DIV128 = 8'h80;
  localparam logic [7:0] DIV192 = 8'hC0;
  // synchroniser vector layout
  localparam int SY_RET = 8;
  localparam int SY_SA = 12;
  localparam int SY_SB = 13;
  localparam int SY_POC = 14;
  localparam int SY_W = 15;
endpackage
